/* File: rtl/coecfg_cfg.svh */
// offsets, field positions, reset values and counts of the event config
// assumes a 32-bit apb bus with one aligned word per register
`ifndef COECFG_CFG_SVH
`define COECFG_CFG_SVH
// register byte offsets
`define COE_OFF_CON1      12'h000
`define COE_OFF_RIS       12'h004
`define COE_OFF_RSIM      12'h008
// control register 1 fields
`define COE_RDBS_BIT      7
`define COE_FDBS_BIT      6
`define COE_POL_MSB       3
`define COE_POL_LSB       0
// writable bits and reset values
`define COE_CON1_WMASK    8'hCF
`define COE_SRC_WMASK     8'h7F
`define COE_CON1_RST      8'h00
`define COE_RIS_RST       8'h00
`define COE_RSIM_RST      8'h00
// phase delay count width and default
`define COE_PH_W          8
`define COE_PH_ZERO       8'h00
`endif

/* File: rtl/coecfg_pkg.sv */
// types shared by the event config block
// assumes the constants header is compiled alongside
package coecfg_pkg;
    // phase delay sequencer
    typedef enum logic [0:0] {
        PH_IDLE  = 1'b0,
        PH_COUNT = 1'b1
    } coecfg_ph_state_t;
    // shutdown override level per output pair
    typedef enum logic [1:0] {
        OVR_INACTIVE = 2'b00,
        OVR_TRISTATE = 2'b01,
        OVR_LOW      = 2'b10,
        OVR_HIGH     = 2'b11
    } coecfg_ovr_t;
endpackage

/* File: rtl/coecfg_top.sv */
// event config slice of a complementary output generator
// assumes apb master on pclk, sources synchronous to pclk
`timescale 1ns/100ps
`include "coecfg_cfg.svh"
module coecfg_top #(
    parameter int AW   = 12,
    parameter int NSRC = 7
) (
    // apb slave
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [AW-1:0]         paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // event sources and timing
    input  wire logic [NSRC-1:0]       rise_src_in,
    input  wire logic                  gen_clk_en,
    input  wire logic [`COE_PH_W-1:0]  rise_phase_count,
    // drive from the steering logic, active high
    input  wire logic [3:0]            drive_in,
    input  wire logic                  shutdown_active,
    input  wire coecfg_pkg::coecfg_ovr_t ovr_ac,
    input  wire coecfg_pkg::coecfg_ovr_t ovr_bd,
    // event and dead-band source outputs
    output logic                       rise_event,
    output logic                       rise_db_chain,
    output logic                       fall_db_chain,
    // output pins a..d
    output logic      [3:0]            out_q,
    output logic      [3:0]            out_oe
);
    import coecfg_pkg::*;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0] con1_ff;
    logic [7:0] ris_ff;
    logic [7:0] rsim_ff;
    logic [7:0] nxt_con1;
    logic [7:0] nxt_ris;
    logic [7:0] nxt_rsim;

    // address decode
    wire        setup_ph  = psel & ~penable;
    wire        wr_fire   = psel & penable & pready & pwrite;
    wire        hit_con1  = (paddr == `COE_OFF_CON1);
    wire        hit_ris   = (paddr == `COE_OFF_RIS);
    wire        hit_rsim  = (paddr == `COE_OFF_RSIM);
    wire        hit_any   = hit_con1 | hit_ris | hit_rsim;
    wire [7:0]  wbyte     = pwdata[7:0];

    // masked write values, unimplemented bits stay zero
    // bits 5:4 of control and bit 7 of enable and mode never store a one
    assign nxt_con1 = (wr_fire & hit_con1) ? (wbyte & `COE_CON1_WMASK) : con1_ff;
    assign nxt_ris  = (wr_fire & hit_ris)  ? (wbyte & `COE_SRC_WMASK)  : ris_ff;
    assign nxt_rsim = (wr_fire & hit_rsim) ? (wbyte & `COE_SRC_WMASK)  : rsim_ff;

    // read mux
    wire [7:0]  rd_byte   = hit_con1 ? con1_ff :
                            hit_ris  ? ris_ff  :
                            hit_rsim ? rsim_ff : 8'h00;

    // register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1_ff <= `COE_CON1_RST;
            ris_ff  <= `COE_RIS_RST;
            rsim_ff <= `COE_RSIM_RST;
        end else begin
            con1_ff <= nxt_con1;
            ris_ff  <= nxt_ris;
            rsim_ff <= nxt_rsim;
        end
    end

    // ----------------------------------------------------------------
    // apb answer, one access cycle
    // ----------------------------------------------------------------
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;

    // answer staged in the setup cycle
    // read data is taken here so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup_ph;
            pslverr_ff <= setup_ph & ~hit_any;
            if (setup_ph & ~pwrite) begin
                prdata_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata  = prdata_ff;

    // ----------------------------------------------------------------
    // rising event source qualification
    // ----------------------------------------------------------------
    logic [NSRC-1:0] src_prev_ff;
    logic [NSRC-1:0] lvl_hit;
    logic [NSRC-1:0] edge_hit;

    // per source: enable gates both modes
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            wire en   = ris_ff[gi];
            wire mode = rsim_ff[gi];
            assign lvl_hit[gi]  = en & ~mode & rise_src_in[gi];
            assign edge_hit[gi] = en & mode & rise_src_in[gi]
                                  & ~src_prev_ff[gi];
        end
    endgenerate

    // any qualified source counts
    wire any_lvl  = |lvl_hit;
    wire any_edge = |edge_hit;

    // previous source levels for edge detection
    // reset low like an idle source, so release gives no false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_ff <= '0;
        end else begin
            src_prev_ff <= rise_src_in;
        end
    end

    // ----------------------------------------------------------------
    // phase delay sequencer for edge mode
    // ----------------------------------------------------------------
    coecfg_ph_state_t        ph_state_ff;
    coecfg_ph_state_t        nxt_ph_state;
    logic [`COE_PH_W-1:0]    ph_cnt_ff;
    logic [`COE_PH_W-1:0]    nxt_ph_cnt;
    logic                    ph_done;

    // count down on module clock enables, edge restarts the delay
    // from idle a zero count skips the wait and fires on the next edge
    always_comb begin
        nxt_ph_state = ph_state_ff;
        nxt_ph_cnt   = ph_cnt_ff;
        ph_done      = 1'b0;
        case (ph_state_ff)
            PH_IDLE: begin
                if (any_edge) begin
                    if (rise_phase_count == `COE_PH_ZERO) begin
                        ph_done = 1'b1;
                    end else begin
                        nxt_ph_state = PH_COUNT;
                        nxt_ph_cnt   = rise_phase_count;
                    end
                end
            end
            PH_COUNT: begin
                if (any_edge) begin
                    nxt_ph_cnt = rise_phase_count;
                end else if (gen_clk_en) begin
                    if (ph_cnt_ff == 8'h01) begin
                        ph_done      = 1'b1;
                        nxt_ph_state = PH_IDLE;
                        nxt_ph_cnt   = `COE_PH_ZERO;
                    end else begin
                        nxt_ph_cnt = ph_cnt_ff - 8'h01;
                    end
                end
            end
            default: begin
                nxt_ph_state = PH_IDLE;
                nxt_ph_cnt   = `COE_PH_ZERO;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_state_ff <= PH_IDLE;
            ph_cnt_ff   <= `COE_PH_ZERO;
        end else begin
            ph_state_ff <= nxt_ph_state;
            ph_cnt_ff   <= nxt_ph_cnt;
        end
    end

    // ----------------------------------------------------------------
    // event and dead-band source outputs
    // ----------------------------------------------------------------
    logic rise_event_ff;
    logic rise_db_chain_ff;
    logic fall_db_chain_ff;

    // level hits pass at once, edges after the phase delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_event_ff    <= 1'b0;
            rise_db_chain_ff <= 1'b0;
            fall_db_chain_ff <= 1'b0;
        end else begin
            rise_event_ff    <= any_lvl | ph_done;
            rise_db_chain_ff <= con1_ff[`COE_RDBS_BIT];
            fall_db_chain_ff <= con1_ff[`COE_FDBS_BIT];
        end
    end

    assign rise_event    = rise_event_ff;
    assign rise_db_chain = rise_db_chain_ff;
    assign fall_db_chain = fall_db_chain_ff;

    // ----------------------------------------------------------------
    // output polarity and shutdown override
    // ----------------------------------------------------------------
    logic [3:0] out_q_ff;
    logic [3:0] out_oe_ff;
    logic [3:0] nxt_q;
    logic [3:0] nxt_oe;
    wire  [3:0] pol = con1_ff[`COE_POL_MSB:`COE_POL_LSB];

    // a,c use the ac override, b,d the bd override
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            coecfg_ovr_t ovr;
            assign ovr = (gi % 2 == 0) ? ovr_ac : ovr_bd;
            assign nxt_q[gi]  = !shutdown_active ? (drive_in[gi] ^ pol[gi]) :
                                (ovr == OVR_HIGH) ? 1'b1 :
                                (ovr == OVR_LOW)  ? 1'b0 : pol[gi];
            assign nxt_oe[gi] = !(shutdown_active && ovr == OVR_TRISTATE);
        end
    endgenerate

    // pin registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q_ff  <= 4'h0;
            out_oe_ff <= 4'h0;
        end else begin
            out_q_ff  <= nxt_q;
            out_oe_ff <= nxt_oe;
        end
    end

    assign out_q  = out_q_ff;
    assign out_oe = out_oe_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_con1_wr;
        wr_fire && hit_con1;
    endsequence

    sequence s_edge_idle;
        any_edge && !any_lvl && ph_state_ff == PH_IDLE && rise_phase_count != 8'h00;
    endsequence

    // setup cycle of an apb transfer
    sequence s_apb_setup;
        psel && !penable;
    endsequence

    // shutdown with the a/c pair at its inactive level
    sequence s_shut_ac_inact;
        shutdown_active && ovr_ac == OVR_INACTIVE;
    endsequence

    // written select bit shows on its output two edges after the write
    property p_rdbs;
        @(posedge pclk) disable iff (!presetn)
        s_con1_wr |-> ##2 rise_db_chain == $past(pwdata[`COE_RDBS_BIT], 2);
    endproperty

    property p_fdbs;
        @(posedge pclk) disable iff (!presetn)
        s_con1_wr |-> ##2 fall_db_chain == $past(pwdata[`COE_FDBS_BIT], 2);
    endproperty

    rdb_select_a: assert property (p_rdbs)
        else $error("rise dead-band source does not follow bit 7");
    fdb_select_a: assert property (p_fdbs)
        else $error("fall dead-band source does not follow bit 6");
    out_polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
        !shutdown_active |=> out_q == ($past(drive_in) ^ $past(pol)))
        else $error("output polarity wrong");
    unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        con1_ff[5:4] == 2'b00 && ris_ff[7] == 1'b0 && rsim_ff[7] == 1'b0)
        else $error("unimplemented bit set");
    edge_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_edge_idle |=> ph_state_ff == PH_COUNT && !rise_event)
        else $error("edge event not delayed by phase");
    level_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_lvl |=> rise_event)
        else $error("level source gave no immediate event");
    disabled_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        ris_ff == 8'h00 && ph_state_ff == PH_IDLE |=> !rise_event)
        else $error("event with all sources disabled");
    reset_zero_a: assert property (@(posedge pclk)
        $rose(presetn) |-> con1_ff == 8'h00 && ris_ff == 8'h00 && rsim_ff == 8'h00)
        else $error("register not zero after reset");
    forced_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown_active && ovr_ac == OVR_LOW |=> out_q[0] == 1'b0 && out_q[2] == 1'b0)
        else $error("forced low override follows polarity");

    // answer timing: ready in the access cycle only, no wait states
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_apb_setup |=> pready)
        else $error("no answer in the access cycle");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held past the access cycle");
    // forced high level of the b/d pair, the inactive level and tristate of the a/c pair
    forced_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown_active && ovr_bd == OVR_HIGH |=> out_q[1] == 1'b1 && out_q[3] == 1'b1)
        else $error("forced high override follows polarity");
    inactive_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_shut_ac_inact |=> out_q[0] == $past(pol[0]) && out_q[2] == $past(pol[2]))
        else $error("inactive override ignores polarity");
    tristate_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown_active && ovr_ac == OVR_TRISTATE |=> out_oe[0] == 1'b0 && out_oe[2] == 1'b0)
        else $error("tristate override still drives");
    // a high source whose enable is clear gives nothing
    src_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        rise_src_in[0] && !ris_ff[0] && (ris_ff[NSRC-1:1] & rise_src_in[NSRC-1:1]) == '0
        && ph_state_ff == PH_IDLE |=> !rise_event)
        else $error("disabled source gave an event");

endmodule // coecfg_top

/* File: bench/coecfg_src_model.sv */
// model of the on-chip event sources feeding the event config slice
// assumes the bench asks for source levels and runs on the same pclk
`timescale 1ns/100ps
module coecfg_src_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // levels asked for by the bench
    input  wire logic [6:0] want,
    // towards the design
    output logic      [6:0] rise_src_in,
    output logic            gen_clk_en
);
    // sources launch just after the edge, module clock enable every other cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_src_in <= 7'h00;
            gen_clk_en  <= 1'b0;
        end else begin
            rise_src_in <= want;
            gen_clk_en  <= ~gen_clk_en;
        end
    end
endmodule // coecfg_src_model

/* File: bench/coecfg_top_tb.sv */
// self-checking bench of the event config slice
// assumes design files and the source model are compiled first
`timescale 1ns/100ps
`include "coecfg_cfg.svh"
module coecfg_top_tb;
    import coecfg_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, gen_clk_en, rise_event, rdb, fdb, shut = 0;
    logic [6:0]  want = 7'h00, src;
    logic [7:0]  phase = 8'h02;
    logic [3:0]  drive = 4'h0, out_q, out_oe;
    coecfg_ovr_t ovr_ac = OVR_INACTIVE, ovr_bd = OVR_INACTIVE;
    int          failures = 0, samples_checked = 0, cyc = 0, ev_cnt = 0, ev_cyc = 0;
    int          c, s;
    logic [11:0] offs [3] = '{`COE_OFF_CON1, `COE_OFF_RIS, `COE_OFF_RSIM};
    logic [7:0]  msk [3] = '{`COE_CON1_WMASK, `COE_SRC_WMASK, `COE_SRC_WMASK};
    // clock, event counter and hang guard
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (rise_event === 1'b1) begin
            ev_cnt++;
            ev_cyc = cyc;
        end
        if (cyc == 4000) begin
            failures++;
            end_of_test();
        end
    end
    coecfg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rise_src_in(src), .gen_clk_en(gen_clk_en),
        .rise_phase_count(phase), .drive_in(drive), .shutdown_active(shut),
        .ovr_ac(ovr_ac), .ovr_bd(ovr_bd), .rise_event(rise_event),
        .rise_db_chain(rdb), .fall_db_chain(fdb), .out_q(out_q), .out_oe(out_oe));
    coecfg_src_model u_src (.pclk(pclk), .presetn(presetn), .want(want),
        .rise_src_in(src), .gen_clk_en(gen_clk_en));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look once the access cycle has settled; the next edge samples pready high
        #1;
        while (pready !== 1'b1) begin
            @(posedge pclk);
            #1;
        end
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, offs[i], 32'h0);
            chk("reset value", 32'h0, rd);
            apb(1'b1, offs[i], 32'hFFFF_FFFF);
            apb(1'b0, offs[i], 32'h0);
            chk("masked readback", {24'h0, msk[i]}, rd);
        end
        apb(1'b1, 12'h00C, 32'h0000_00FF);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, `COE_OFF_CON1, 32'h0000_00C0);
        wait_n(2);
        chk("db sources set", 32'h3, {30'h0, rdb, fdb});
        apb(1'b1, `COE_OFF_CON1, 32'h0000_0040);
        wait_n(2);
        chk("db sources mixed", 32'h1, {30'h0, rdb, fdb});
        $display("test regs done");
    endtask
    task automatic t_pol();
        apb(1'b1, `COE_OFF_CON1, 32'h0000_0005);
        @(posedge pclk) drive <= 4'hF;
        wait_n(3);
        chk("out active", 32'hA, {28'h0, out_q});
        @(posedge pclk) begin drive <= 4'h0; shut <= 1'b1; ovr_ac <= OVR_LOW; ovr_bd <= OVR_HIGH; end
        wait_n(3);
        chk("forced levels", 32'hA, {28'h0, out_q});
        @(posedge pclk) begin ovr_ac <= OVR_INACTIVE; ovr_bd <= OVR_INACTIVE; end
        wait_n(3);
        chk("inactive levels", 32'h5, {28'h0, out_q});
        @(posedge pclk) ovr_ac <= OVR_TRISTATE;
        wait_n(3);
        chk("tristate enables", 32'hA, {28'h0, out_oe});
        @(posedge pclk) begin shut <= 1'b0; ovr_ac <= OVR_INACTIVE; end
        $display("test polarity done");
    endtask
    task automatic t_level();
        apb(1'b1, `COE_OFF_RIS, 32'h0000_007F);
        apb(1'b1, `COE_OFF_RSIM, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            c = ev_cnt;
            @(posedge pclk) want <= 7'(1 << i);
            wait_n(5);
            @(posedge pclk) want <= 7'h00;
            wait_n(3);
            chk("level events", 32'h6, 32'(ev_cnt - c));
        end
        apb(1'b1, `COE_OFF_RIS, 32'h0000_007E);
        c = ev_cnt;
        @(posedge pclk) want <= 7'h01;
        wait_n(6);
        @(posedge pclk) want <= 7'h00;
        wait_n(3);
        chk("disabled source", 32'(c), 32'(ev_cnt));
        $display("test level done");
    endtask
    task automatic t_edge();
        apb(1'b1, `COE_OFF_RIS, 32'h0000_0001);
        apb(1'b1, `COE_OFF_RSIM, 32'h0000_0001);
        @(posedge pclk) want <= 7'h01;
        #1;
        c = ev_cnt;
        s = cyc;
        wait_n(14);
        chk("edge event count", 32'(c + 1), 32'(ev_cnt));
        // two module clock ticks at half rate: event counted 6 or 7 edges on
        chk("phase delay seen", 32'h1, {31'h0, (ev_cyc - s) >= 6 && (ev_cyc - s) <= 7});
        @(posedge pclk) want <= 7'h00;
        $display("test edge done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pol();
        t_level();
        t_edge();
        end_of_test();
    end
endmodule // coecfg_top_tb
